// File: bsisp_tap.sv
// test access port controller, instruction decode and isp programming of the test port
module bsisp_tap #(
    parameter int N_IO = bsisp_pkg::N_IO_DEF,
    parameter int N_IN = bsisp_pkg::N_IN_DEF,
    parameter int N_MC = bsisp_pkg::N_MC_DEF,
    parameter int CFG_W = bsisp_pkg::CFG_W_DEF,
    // arbitrary identification value, bit 0 must stay one
    parameter logic [bsisp_pkg::ID_W-1:0] ID_VALUE = 32'h0a5a_5001
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // configuration options
    input wire logic jtag_en,
    input wire logic pullup_en,
    // the four test port pins
    input wire logic [bsisp_pkg::JP_N-1:0] jp_in,
    output logic [bsisp_pkg::JP_N-1:0] jp_out,
    output logic [bsisp_pkg::JP_N-1:0] jp_oe,
    output logic tms_pullup,
    output logic tdi_pullup,
    // test pins as user I/O when the port is disabled
    output logic [bsisp_pkg::JP_N-1:0] user_jp_in,
    input wire logic [bsisp_pkg::JP_N-1:0] user_jp_out,
    input wire logic [bsisp_pkg::JP_N-1:0] user_jp_oe,
    // device pads: dedicated inputs low, I/O above
    input wire logic [N_IN+N_IO-1:0] pad_in,
    output logic [N_IO-1:0] pad_out,
    output logic [N_IO-1:0] pad_oe,
    // core logic side
    output logic [N_IN+N_IO-1:0] core_in,
    input wire logic [N_IO-1:0] core_out,
    input wire logic [N_IO-1:0] core_oe,
    input wire logic [N_MC-1:0] mc_out,
    input wire logic [N_MC-1:0] mc_fb,
    input wire logic [N_MC-1:0] mc_oe,
    output logic [N_MC-1:0] mc_value,
    // programmed configuration
    output logic [CFG_W-1:0] cfg_word,
    output logic isp_busy,
    output logic isp_locked
);
    localparam int N_PIN = N_IN + N_IO;

    bsisp_scan_if scan ();

    // synchronisers: the first stage feeds only the second
    logic [bsisp_pkg::JP_N-1:0] jp_meta;
    logic [bsisp_pkg::JP_N-1:0] jp_s;
    logic [N_PIN-1:0] pad_meta;
    logic [N_PIN-1:0] pad_s;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            jp_meta <= '0;
            jp_s <= '0;
            pad_meta <= '0;
            pad_s <= '0;
        end else begin
            jp_meta <= jp_in;
            jp_s <= jp_meta;
            pad_meta <= pad_in;
            pad_s <= pad_meta;
        end
    end

    bsisp_pkg::bsisp_state_t state;
    bsisp_pkg::bsisp_state_t next_state;
    logic tck_d;
    logic [bsisp_pkg::IR_W-1:0] ir;
    logic [bsisp_pkg::IR_W-1:0] next_ir;
    logic [bsisp_pkg::IR_W-1:0] ir_sr;
    logic [bsisp_pkg::IR_W-1:0] next_ir_sr;
    logic byp;
    logic next_byp;
    logic [bsisp_pkg::ID_W-1:0] id_sr;
    logic [bsisp_pkg::ID_W-1:0] next_id_sr;
    logic [CFG_W-1:0] cfg_sr;
    logic [CFG_W-1:0] next_cfg_sr;
    logic [CFG_W-1:0] next_cfg_word;
    logic next_isp_busy;
    logic next_isp_locked;
    logic tdo;
    logic next_tdo;
    logic tdo_oe;
    logic next_tdo_oe;
    logic [bsisp_pkg::JP_N-1:0] next_jp_out;
    logic [bsisp_pkg::JP_N-1:0] next_jp_oe;
    logic [bsisp_pkg::JP_N-1:0] next_user_jp_in;
    logic [N_IO-1:0] next_pad_out;
    logic [N_IO-1:0] next_pad_oe;
    logic [N_PIN-1:0] pin_out;
    logic [N_PIN-1:0] pin_oe;
    logic [N_MC-1:0] cell_mc;

    // tck is only sampled; at 25 mclk per tck period edges are found reliably
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic sel_bsr;
    logic sel_id;
    logic sel_cfg;
    logic abort;

    assign tck_rise = jtag_en & jp_s[bsisp_pkg::JP_TCK] & ~tck_d;
    assign tck_fall = jtag_en & ~jp_s[bsisp_pkg::JP_TCK] & tck_d;
    assign tms = jp_s[bsisp_pkg::JP_TMS];
    assign tdi = jp_s[bsisp_pkg::JP_TDI];

    // data register selection; highz and unknown codes use bypass
    assign sel_bsr = (ir == bsisp_pkg::IR_EXTEST) || (ir == bsisp_pkg::IR_SAMPLE);
    assign sel_id = (ir == bsisp_pkg::IR_IDCODE);
    assign sel_cfg = (ir == bsisp_pkg::IR_PROGRAM);

    // capture, shift and update derive from the controller state; extest and highz from the instruction
    assign scan.capture = tck_rise & (state == bsisp_pkg::ST_CAP_DR) & sel_bsr;
    assign scan.shift = tck_rise & (state == bsisp_pkg::ST_SHIFT_DR) & sel_bsr;
    assign scan.update = tck_fall & (state == bsisp_pkg::ST_UPD_DR) & sel_bsr;
    assign scan.extest = (ir == bsisp_pkg::IR_EXTEST);
    assign scan.highz = (ir == bsisp_pkg::IR_HIGHZ);
    assign scan.scan_in = tdi;

    // a session ends cleanly only through update-dr; anything else aborts it
    assign abort = isp_busy & (~jtag_en | (state == bsisp_pkg::ST_RESET)
                   | (tck_rise & (state == bsisp_pkg::ST_UPD_IR)));

    bsisp_chain #(
        .N_PIN(N_PIN),
        .N_MC(N_MC)
    ) u_chain (
        .mclk(mclk),
        .rst(rst),
        .scan(scan.chain),
        .pin_in(pad_s),
        .core_out({core_out, {N_IN{1'b0}}}),
        .core_oe({core_oe, {N_IN{1'b0}}}),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .mc_out(mc_out),
        .mc_fb(mc_fb),
        .mc_oe(mc_oe),
        .mc_value(cell_mc)
    );

    always_comb begin
        next_state = state;
        if (!jtag_en) begin
            next_state = bsisp_pkg::ST_RESET;
        end else if (tck_rise) begin
            case (state)
                bsisp_pkg::ST_RESET: next_state = tms ? bsisp_pkg::ST_RESET : bsisp_pkg::ST_IDLE;
                bsisp_pkg::ST_IDLE: next_state = tms ? bsisp_pkg::ST_SEL_DR : bsisp_pkg::ST_IDLE;
                bsisp_pkg::ST_SEL_DR: next_state = tms ? bsisp_pkg::ST_SEL_IR : bsisp_pkg::ST_CAP_DR;
                bsisp_pkg::ST_CAP_DR: next_state = tms ? bsisp_pkg::ST_EXIT1_DR : bsisp_pkg::ST_SHIFT_DR;
                bsisp_pkg::ST_SHIFT_DR: next_state = tms ? bsisp_pkg::ST_EXIT1_DR : bsisp_pkg::ST_SHIFT_DR;
                bsisp_pkg::ST_EXIT1_DR: next_state = tms ? bsisp_pkg::ST_UPD_DR : bsisp_pkg::ST_PAUSE_DR;
                bsisp_pkg::ST_PAUSE_DR: next_state = tms ? bsisp_pkg::ST_EXIT2_DR : bsisp_pkg::ST_PAUSE_DR;
                bsisp_pkg::ST_EXIT2_DR: next_state = tms ? bsisp_pkg::ST_UPD_DR : bsisp_pkg::ST_SHIFT_DR;
                bsisp_pkg::ST_UPD_DR: next_state = tms ? bsisp_pkg::ST_SEL_DR : bsisp_pkg::ST_IDLE;
                bsisp_pkg::ST_SEL_IR: next_state = tms ? bsisp_pkg::ST_RESET : bsisp_pkg::ST_CAP_IR;
                bsisp_pkg::ST_CAP_IR: next_state = tms ? bsisp_pkg::ST_EXIT1_IR : bsisp_pkg::ST_SHIFT_IR;
                bsisp_pkg::ST_SHIFT_IR: next_state = tms ? bsisp_pkg::ST_EXIT1_IR : bsisp_pkg::ST_SHIFT_IR;
                bsisp_pkg::ST_EXIT1_IR: next_state = tms ? bsisp_pkg::ST_UPD_IR : bsisp_pkg::ST_PAUSE_IR;
                bsisp_pkg::ST_PAUSE_IR: next_state = tms ? bsisp_pkg::ST_EXIT2_IR : bsisp_pkg::ST_PAUSE_IR;
                bsisp_pkg::ST_EXIT2_IR: next_state = tms ? bsisp_pkg::ST_UPD_IR : bsisp_pkg::ST_SHIFT_IR;
                bsisp_pkg::ST_UPD_IR: next_state = tms ? bsisp_pkg::ST_SEL_DR : bsisp_pkg::ST_IDLE;
                default: next_state = bsisp_pkg::ST_RESET;
            endcase
        end
    end

    always_comb begin
        next_ir = ir;
        next_ir_sr = ir_sr;
        next_byp = byp;
        next_id_sr = id_sr;
        next_cfg_sr = cfg_sr;
        next_cfg_word = cfg_word;
        next_isp_busy = isp_busy;
        next_isp_locked = isp_locked;
        next_tdo = tdo;
        next_tdo_oe = tdo_oe;
        if (state == bsisp_pkg::ST_RESET) begin
            next_ir = bsisp_pkg::IR_RESET;
        end
        if (tck_rise) begin
            case (state)
                bsisp_pkg::ST_CAP_IR: next_ir_sr = bsisp_pkg::IR_CAPTURE;
                bsisp_pkg::ST_SHIFT_IR: next_ir_sr = {tdi, ir_sr[bsisp_pkg::IR_W-1:1]};
                bsisp_pkg::ST_CAP_DR: begin
                    next_byp = 1'b0;
                    next_id_sr = ID_VALUE;
                    next_cfg_sr = cfg_word;
                end
                bsisp_pkg::ST_SHIFT_DR: begin
                    next_byp = tdi;
                    if (sel_id) begin
                        next_id_sr = {tdi, id_sr[bsisp_pkg::ID_W-1:1]};
                    end
                    if (sel_cfg) begin
                        next_cfg_sr = {tdi, cfg_sr[CFG_W-1:1]};
                        next_isp_busy = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (tck_fall) begin
            case (state)
                bsisp_pkg::ST_UPD_IR: next_ir = ir_sr;
                bsisp_pkg::ST_UPD_DR: begin
                    if (sel_cfg && isp_busy) begin
                        next_cfg_word = cfg_sr;
                        next_isp_busy = 1'b0;
                        next_isp_locked = 1'b0;
                    end
                end
                default: begin
                end
            endcase
            // tdo changes on the falling edge, driven only while shifting
            next_tdo_oe = (state == bsisp_pkg::ST_SHIFT_IR) || (state == bsisp_pkg::ST_SHIFT_DR);
            if (state == bsisp_pkg::ST_SHIFT_IR) begin
                next_tdo = ir_sr[0];
            end else if (sel_bsr) begin
                next_tdo = scan.scan_out;
            end else if (sel_id) begin
                next_tdo = id_sr[0];
            end else if (sel_cfg) begin
                next_tdo = cfg_sr[0];
            end else begin
                next_tdo = byp;
            end
        end
        if (!jtag_en) begin
            next_tdo_oe = 1'b0;
        end
        if (abort) begin
            next_isp_busy = 1'b0;
            next_isp_locked = 1'b1;
        end
    end

    // pin outputs; a lock releases every pad, and the test port pins while they serve as user I/O
    always_comb begin
        next_pad_out = pin_out[N_IN +: N_IO];
        next_pad_oe = (isp_locked || abort) ? '0 : pin_oe[N_IN +: N_IO];
        next_jp_out = '0;
        next_jp_oe = '0;
        next_user_jp_in = '0;
        if (jtag_en) begin
            next_jp_out[bsisp_pkg::JP_TDO] = tdo;
            next_jp_oe[bsisp_pkg::JP_TDO] = tdo_oe;
        end else begin
            next_jp_out = user_jp_out;
            next_jp_oe = (isp_locked || abort) ? '0 : user_jp_oe;
            next_user_jp_in = jp_s;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= bsisp_pkg::ST_RESET;
            tck_d <= 1'b0;
            ir <= bsisp_pkg::IR_RESET;
            ir_sr <= '0;
            byp <= 1'b0;
            id_sr <= '0;
            cfg_sr <= '0;
            cfg_word <= '0;
            isp_busy <= 1'b0;
            isp_locked <= 1'b0;
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
            jp_out <= '0;
            jp_oe <= '0;
            user_jp_in <= '0;
            tms_pullup <= 1'b0;
            tdi_pullup <= 1'b0;
            pad_out <= '0;
            pad_oe <= '0;
            core_in <= '0;
            mc_value <= '0;
        end else begin
            state <= next_state;
            tck_d <= jp_s[bsisp_pkg::JP_TCK];
            ir <= next_ir;
            ir_sr <= next_ir_sr;
            byp <= next_byp;
            id_sr <= next_id_sr;
            cfg_sr <= next_cfg_sr;
            cfg_word <= next_cfg_word;
            isp_busy <= next_isp_busy;
            isp_locked <= next_isp_locked;
            tdo <= next_tdo;
            tdo_oe <= next_tdo_oe;
            jp_out <= next_jp_out;
            jp_oe <= next_jp_oe;
            user_jp_in <= next_user_jp_in;
            tms_pullup <= jtag_en & pullup_en;
            tdi_pullup <= jtag_en & pullup_en;
            pad_out <= next_pad_out;
            pad_oe <= next_pad_oe;
            core_in <= pad_s;
            mc_value <= cell_mc;
        end
    end
endmodule

// File: bsisp_pkg.sv
// constants, codes and state type for the boundary-scan and isp test port
package bsisp_pkg;

    // default pin and cell counts
    localparam int N_IO_DEF = 68;
    localparam int N_IN_DEF = 4;
    localparam int N_MC_DEF = 64;
    localparam int CFG_W_DEF = 16;

    // every cell holds three capture stages
    localparam int CELL_W = 3;
    localparam int CAP_PIN = 0;
    localparam int CAP_OUT = 1;
    localparam int CAP_OE = 2;

    // instruction register
    localparam int IR_W = 4;
    localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] IR_HIGHZ = 4'h3;
    localparam logic [IR_W-1:0] IR_PROGRAM = 4'h8;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] IR_RESET = IR_IDCODE;

    // identification register width
    localparam int ID_W = 32;

    // positions of the four test port pins in the jp_* vectors
    localparam int JP_TCK = 0;
    localparam int JP_TMS = 1;
    localparam int JP_TDI = 2;
    localparam int JP_TDO = 3;
    localparam int JP_N = 4;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bsisp_state_t;

endpackage

// File: bsisp_scan_if.sv
// control and serial data between the port controller and the cell chain
interface bsisp_scan_if;
    logic capture;
    logic shift;
    logic update;
    logic extest;
    logic highz;
    logic scan_in;
    logic scan_out;

    modport tap (output capture, output shift, output update, output extest, output highz,
                 output scan_in, input scan_out);
    modport chain (input capture, input shift, input update, input extest, input highz,
                   input scan_in, output scan_out);
endinterface

// File: bsisp_chain.sv
// boundary-scan cell chain: pin cells first, then macrocell cells
module bsisp_chain #(
    parameter int N_PIN = 72,
    parameter int N_MC = 64
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // controller side
    bsisp_scan_if.chain scan,
    // pin cells
    input wire logic [N_PIN-1:0] pin_in,
    input wire logic [N_PIN-1:0] core_out,
    input wire logic [N_PIN-1:0] core_oe,
    output logic [N_PIN-1:0] pin_out,
    output logic [N_PIN-1:0] pin_oe,
    // macrocell cells
    input wire logic [N_MC-1:0] mc_out,
    input wire logic [N_MC-1:0] mc_fb,
    input wire logic [N_MC-1:0] mc_oe,
    output logic [N_MC-1:0] mc_value
);
    localparam int LEN = bsisp_pkg::CELL_W * (N_PIN + N_MC);

    logic [LEN-1:0] sr;
    logic [LEN-1:0] next_sr;
    logic [LEN-1:0] cap;
    logic [N_PIN-1:0] upd_out;
    logic [N_PIN-1:0] upd_oe;
    logic [N_PIN-1:0] next_upd_out;
    logic [N_PIN-1:0] next_upd_oe;
    logic [N_MC-1:0] upd_mc;
    logic [N_MC-1:0] next_upd_mc;

    // pin variant: pin level, core output, core enable; two update stages
    for (genvar i = 0; i < N_PIN; i++) begin : g_pin
        assign cap[bsisp_pkg::CELL_W*i +: bsisp_pkg::CELL_W] = {core_oe[i], core_out[i], pin_in[i]};
    end
    // macrocell variant: output, feedback, enable; one update stage
    for (genvar j = 0; j < N_MC; j++) begin : g_mc
        assign cap[bsisp_pkg::CELL_W*(N_PIN+j) +: bsisp_pkg::CELL_W] = {mc_oe[j], mc_fb[j], mc_out[j]};
    end

    always_comb begin
        next_sr = sr;
        next_upd_out = upd_out;
        next_upd_oe = upd_oe;
        next_upd_mc = upd_mc;
        if (scan.capture) begin
            next_sr = cap;
        end else if (scan.shift) begin
            next_sr = {scan.scan_in, sr[LEN-1:1]};
        end
        if (scan.update) begin
            for (int i = 0; i < N_PIN; i++) begin
                next_upd_out[i] = sr[bsisp_pkg::CELL_W*i + bsisp_pkg::CAP_OUT];
                next_upd_oe[i] = sr[bsisp_pkg::CELL_W*i + bsisp_pkg::CAP_OE];
            end
            for (int j = 0; j < N_MC; j++) begin
                next_upd_mc[j] = sr[bsisp_pkg::CELL_W*(N_PIN+j) + bsisp_pkg::CAP_PIN];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sr <= '0;
            upd_out <= '0;
            upd_oe <= '0;
            upd_mc <= '0;
        end else begin
            sr <= next_sr;
            upd_out <= next_upd_out;
            upd_oe <= next_upd_oe;
            upd_mc <= next_upd_mc;
        end
    end

    assign scan.scan_out = sr[0];
    // extest drives pins from update stages; highz releases every pin
    assign pin_out = scan.extest ? upd_out : core_out;
    assign pin_oe = scan.highz ? '0 : (scan.extest ? upd_oe : core_oe);
    assign mc_value = scan.extest ? upd_mc : mc_out;
endmodule

// File: bsisp_tap_assertions.sv
// port-level assertions for the boundary-scan and isp test port
module bsisp_checker #(
    parameter int N_IO = 68,
    parameter int N_IN = 4,
    parameter int N_MC = 64,
    parameter int CFG_W = 16
) (
    // clock, reset and options
    input wire logic mclk,
    input wire logic rst,
    input wire logic jtag_en,
    input wire logic pullup_en,
    // test pins
    input wire logic [3:0] jp_out,
    input wire logic [3:0] jp_oe,
    input wire logic tms_pullup,
    input wire logic tdi_pullup,
    input wire logic [3:0] user_jp_in,
    input wire logic [3:0] user_jp_out,
    input wire logic [3:0] user_jp_oe,
    // pads and core
    input wire logic [N_IN+N_IO-1:0] pad_in,
    input wire logic [N_IO-1:0] pad_out,
    input wire logic [N_IO-1:0] pad_oe,
    input wire logic [N_IN+N_IO-1:0] core_in,
    input wire logic [N_IO-1:0] core_out,
    input wire logic [N_IO-1:0] core_oe,
    input wire logic [N_MC-1:0] mc_out,
    input wire logic [N_MC-1:0] mc_value,
    // programming
    input wire logic [CFG_W-1:0] cfg_word,
    input wire logic isp_busy,
    input wire logic isp_locked
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    chk_pullup_on: assert property ((jtag_en && pullup_en)[*2] |-> tms_pullup && tdi_pullup)
        else $error("pull-up off with option set");
    chk_pullup_off: assert property ((!jtag_en || !pullup_en)[*2] |-> !tms_pullup && !tdi_pullup)
        else $error("pull-up on without option");
    chk_user_out: assert property (!jtag_en[*2] |-> jp_out == $past(user_jp_out))
        else $error("test pin value not user value");
    chk_user_oe: assert property ((!jtag_en && !isp_locked)[*2] |-> jp_oe == $past(user_jp_oe))
        else $error("test pin enable not user enable");
    chk_only_tdo: assert property (jtag_en[*2] |-> jp_oe[2:0] == 3'h0 && user_jp_in == 4'h0)
        else $error("test input pin driven or passed on");
    chk_lock_release: assert property (isp_locked[*2] |-> pad_oe == '0)
        else $error("pad driven while locked");
    chk_lock_cause: assert property ($rose(isp_locked) |-> $past(isp_busy))
        else $error("lock without a session");
    chk_cfg_write: assert property ($changed(cfg_word) |-> $past(isp_busy) && !isp_locked)
        else $error("configuration changed outside a session");
    chk_core_path: assert property ($stable(pad_in)[*4] |-> core_in == pad_in)
        else $error("pad value not passed to core");
    chk_normal_pads: assert property ((!jtag_en && !isp_locked)[*4] |->
        pad_out == $past(core_out) && pad_oe == $past(core_oe) && mc_value == $past(mc_out))
        else $error("pads not following core");
endmodule

bind bsisp_tap bsisp_checker #(.N_IO(N_IO), .N_IN(N_IN), .N_MC(N_MC), .CFG_W(CFG_W)) chk (
    .mclk(mclk), .rst(rst), .jtag_en(jtag_en), .pullup_en(pullup_en), .jp_out(jp_out), .jp_oe(jp_oe),
    .tms_pullup(tms_pullup), .tdi_pullup(tdi_pullup), .user_jp_in(user_jp_in), .user_jp_out(user_jp_out),
    .user_jp_oe(user_jp_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .core_in(core_in),
    .core_out(core_out), .core_oe(core_oe), .mc_out(mc_out), .mc_value(mc_value), .cfg_word(cfg_word),
    .isp_busy(isp_busy), .isp_locked(isp_locked));

// File: bsisp_tester.sv
// tester model: makes the test clock, drives mode select and data in, samples data out
module bsisp_tester (
    // link pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one 125 ns period; inputs change while the clock is low, so they stand well around the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5;
        q = tdo;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask
    // idle to shift, n bits lsb first, then update and idle; an unfinished scan stops in shift
    task automatic scan(input logic ir, input int n, input logic [511:0] din, input logic full,
                        output logic [511:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) step(full && i == n - 1, din[i], dout[i]);
        if (full) begin
            step(1'b1, 1'b0, q);
            step(1'b0, 1'b0, q);
        end
    endtask
endmodule

// File: boundary_scan_tap_isp_port_test.sv
// self-checking bench for the boundary-scan and isp test port
module boundary_scan_tap_isp_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NI = bsisp_pkg::N_IN_DEF;
    localparam int NO = bsisp_pkg::N_IO_DEF;
    localparam int NM = bsisp_pkg::N_MC_DEF;
    localparam int NP = NI + NO;
    localparam int CW = bsisp_pkg::CFG_W_DEF;
    localparam logic [31:0] ID = 32'h1c3b_7e45; // arbitrary identification value
    logic mclk, rst, jtag_en, pullup_en, tck, tms, tdi, tdo_hold, q;
    logic [3:0] jp_in, jp_out, jp_oe, user_jp_in, user_jp_out, user_jp_oe;
    logic [NP-1:0] pad_in, core_in;
    logic [NO-1:0] pad_out, pad_oe, core_out, core_oe;
    logic [NM-1:0] mc_out, mc_fb, mc_oe, mc_value;
    logic [CW-1:0] cfg_word, cfg_exp;
    logic tms_pullup, tdi_pullup, isp_busy, isp_locked;
    logic [511:0] din, dout, exp, msk;
    logic [31:0] seed = 32'hc;
    int errors = 0, samples_checked = 0, cycles = 0;
    // a released data-out pin shows the inverse of its last driven level
    always @(posedge mclk) if (jp_oe[3]) tdo_hold <= jp_out[3];
    assign jp_in[3] = jp_oe[3] ? jp_out[3] : ~tdo_hold;
    assign jp_in[2:0] = (jp_oe[2:0] & jp_out[2:0]) | (~jp_oe[2:0] & {tdi, tms, tck});
    bsisp_tap #(.ID_VALUE(ID)) dut (.mclk(mclk), .rst(rst), .jtag_en(jtag_en), .pullup_en(pullup_en),
        .jp_in(jp_in), .jp_out(jp_out), .jp_oe(jp_oe), .tms_pullup(tms_pullup), .tdi_pullup(tdi_pullup),
        .user_jp_in(user_jp_in), .user_jp_out(user_jp_out), .user_jp_oe(user_jp_oe), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .core_in(core_in), .core_out(core_out), .core_oe(core_oe),
        .mc_out(mc_out), .mc_fb(mc_fb), .mc_oe(mc_oe), .mc_value(mc_value), .cfg_word(cfg_word),
        .isp_busy(isp_busy), .isp_locked(isp_locked));
    bsisp_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(jp_in[3]));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            $display("mismatch %0t timeout", $time);
            complete_run();
        end
    end
    task automatic complete_run();
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [511:0] got, input logic [511:0] want, input string what);
        samples_checked++;
        if (got !== want) begin
            errors++;
            $display("mismatch %0t %s got %0h want %0h", $time, what, got, want);
        end
    endtask
    function automatic logic [511:0] rvec();
        logic [511:0] v;
        for (int k = 0; k < 16; k++) begin
            seed ^= seed << 13;
            seed ^= seed >> 17;
            seed ^= seed << 5;
            v[32*k+:32] = seed;
        end
        return v;
    endfunction
    // captured chain image; input pins have their core output and enable tied to zero, so their upper bits are masked
    function automatic void sample_image();
        exp = '0;
        msk = '0;
        for (int i = 0; i < NP; i++) begin
            exp[3*i+:3] = (i < NI) ? {2'h0, pad_in[i]} : {core_oe[i-NI], core_out[i-NI], pad_in[i]};
            msk[3*i+:3] = (i < NI) ? 3'h1 : 3'h7;
        end
        for (int j = 0; j < NM; j++) begin
            exp[3*(NP+j)+:3] = {mc_oe[j], mc_fb[j], mc_out[j]};
            msk[3*(NP+j)+:3] = 3'h7;
        end
    endfunction
    // update-stage image packed as macrocell values, pad enables, pad values
    function automatic void update_image();
        exp = '0;
        for (int k = 0; k < NO; k++) begin
            exp[k] = din[3*(NI+k)+1];
            exp[NO+k] = din[3*(NI+k)+2];
        end
        for (int j = 0; j < NM; j++) exp[2*NO+j] = din[3*(NP+j)];
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic load_ir(input logic [3:0] code);
        tester.scan(1'b1, 4, 512'(code), 1'b1, dout);
        check(512'(dout[3:0]), 512'(bsisp_pkg::IR_CAPTURE), "ir capture");
        tick(6);
    endtask
    task automatic one_bit();
        din = rvec();
        tester.scan(1'b0, 16, din, 1'b1, dout);
        check(512'(dout[15:0]), 512'({din[14:0], 1'b0}), "bypass");
    endtask
    task automatic prog_cfg(input logic full);
        load_ir(bsisp_pkg::IR_PROGRAM);
        din = rvec();
        tester.scan(1'b0, full ? CW : 3, din, full, dout);
        tick(6);
    endtask
    initial begin
        rst = 1'b1;
        jtag_en = 1'b1;
        pullup_en = 1'b0;
        tdo_hold = 1'b0;
        user_jp_out = 4'h0;
        user_jp_oe = 4'h0;
        {pad_in, core_out, core_oe} = '0;
        {mc_out, mc_fb, mc_oe} = '0;
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
        tick(4);
        check(512'({tms_pullup, tdi_pullup}), 512'(0), "pull-up off");
        pullup_en = 1'b1;
        tick(4);
        check(512'({tms_pullup, tdi_pullup}), 512'(3), "pull-up on");
        tester.step(1'b0, 1'b0, q);
        din = rvec();
        tester.scan(1'b0, 32, din, 1'b1, dout);
        check(512'(dout[31:0]), 512'(ID), "idcode");
        load_ir(bsisp_pkg::IR_BYPASS);
        one_bit();
        tick(1);
        din = rvec();
        {core_oe, core_out, pad_in} = din[NP+2*NO-1:0];
        din = rvec();
        {mc_oe, mc_fb, mc_out} = din[3*NM-1:0];
        load_ir(bsisp_pkg::IR_SAMPLE);
        sample_image();
        din = rvec();
        tester.scan(1'b0, 3 * (NP + NM), din, 1'b1, dout);
        check(dout & msk, exp & msk, "sample");
        tick(4);
        check(512'({pad_oe, pad_out}), 512'({core_oe, core_out}), "pads in sample");
        load_ir(bsisp_pkg::IR_EXTEST);
        update_image();
        check(512'({mc_value, pad_oe, pad_out}), exp, "extest");
        load_ir(bsisp_pkg::IR_HIGHZ);
        check(512'(pad_oe), 512'(0), "highz");
        one_bit();
        prog_cfg(1'b1);
        cfg_exp = din[CW-1:0];
        check(512'({isp_locked, isp_busy, dout[CW-1:0], cfg_word}), 512'({18'h0, cfg_exp}), "program");
        prog_cfg(1'b0);
        check(512'(isp_busy), 512'(1), "session open");
        jtag_en = 1'b0;
        user_jp_out = 4'ha;
        user_jp_oe = 4'hf;
        tick(6);
        check(512'({isp_locked, isp_busy, pad_oe, cfg_word}), 512'({2'h2, {NO{1'b0}}, cfg_exp}), "abort");
        check(512'({jp_oe, jp_out}), 512'(8'h0a), "locked pins");
        jtag_en = 1'b1;
        tick(4);
        tester.step(1'b0, 1'b0, q);
        prog_cfg(1'b1);
        check(512'({isp_locked, cfg_word}), 512'(din[CW-1:0]), "relock clear");
        repeat (5) tester.step(1'b1, 1'b0, q);
        tester.step(1'b0, 1'b0, q);
        tester.scan(1'b0, 32, din, 1'b1, dout);
        check(512'(dout[31:0]), 512'(ID), "tms reset");
        jtag_en = 1'b0;
        for (int n = 0; n < 4; n++) begin
            din = rvec();
            user_jp_out = din[3:0];
            user_jp_oe = (n == 0) ? 4'hf : {1'b1, din[6:4]};
            tick(6);
            exp = 512'((user_jp_oe & user_jp_out) | (~user_jp_oe & {1'b0, tdi, tms, tck}));
            check(512'({jp_oe, jp_out}), 512'({user_jp_oe, user_jp_out}), "user out");
            check(512'(user_jp_in), exp, "user in");
            check(512'({tms_pullup, tdi_pullup}), 512'(0), "pull-up port off");
        end
        complete_run();
    end
endmodule
